// [hw/wdt_top.sv]
// Watchdog timer with NMI output and AHB-Lite control registers
`timescale 1ns/1ps
`default_nettype none
module wdt_top
  import wdt_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic SLOW_OSC,
  input wire logic FAST_OSC,
  output logic NMI_REQ,
  output logic IRQ
);
  // Address decode, called only by the bus slave to set the data-phase select
  function automatic wdt_sel_e decode_addr(input logic [31:0] addr);
    if (addr == CTRL_ADDR) begin
      decode_addr = SEL_CTRL;
    end else if (addr == STAT_ADDR) begin
      decode_addr = SEL_STAT;
    end else if (addr == MASK_ADDR) begin
      decode_addr = SEL_MASK;
    end else begin
      decode_addr = SEL_NONE;
    end
  endfunction

  logic [1:0] osc_pin;
  logic [1:0] osc_level;
  logic [1:0] osc_tick;
  logic tick_sel;
  logic [CNT_W-1:0] count;
  logic write_unlock;
  logic nmi_enable;
  logic count_clock_select;
  logic [STS_W-1:0] status;
  logic [STS_W-1:0] mask;
  logic [STS_W-1:0] next_status;
  wdt_bus_e bus_state;
  wdt_sel_e dp_sel;
  logic addr_ok;
  logic ctrl_wr;
  logic [7:0] wbyte;
  logic restart_wr;
  logic prot_change;
  logic ovf_evt;

  assign osc_pin = {FAST_OSC, SLOW_OSC};

  // One synchroniser and prescaler per oscillator
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_osc
      wdt_sync3 u_sync (
        .clk(CLK),
        .rst(SYS_RST),
        .din(osc_pin[gi]),
        .level(osc_level[gi])
      );
      wdt_tick_div u_div (
        .clk(CLK),
        .rst(SYS_RST),
        .level(osc_level[gi]),
        .tick(osc_tick[gi])
      );
    end
  endgenerate

  // Tick choice follows the select bit
  assign tick_sel = count_clock_select ? osc_tick[1] : osc_tick[0];

  // Bus data-phase decode
  assign addr_ok = HSEL && HREADY && HTRANS[1];
  assign ctrl_wr = (bus_state == BUS_WR) && (dp_sel == SEL_CTRL);
  assign wbyte = HWDATA[7:0];
  assign restart_wr = ctrl_wr && wbyte[BIT_RESTART];
  // A protected write is one that would alter enable or select
  assign prot_change = (wbyte[BIT_NMI_EN] != nmi_enable) ||
                       (wbyte[BIT_CLK_SEL] != count_clock_select);

  // Wrap from all ones is the overflow; a restart in that cycle wins
  assign ovf_evt = tick_sel && (count == CNT_MAX) && !restart_wr;

  // Up-counter; the enable bit never gates it
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      count <= CNT_RST;
    end else if (restart_wr) begin
      count <= CNT_RST;
    end else if (tick_sel) begin
      count <= count + 1'b1;
    end
  end

  // Unlock bit: set by write, cleared by a protected update or by zero
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      write_unlock <= RST_UNLOCK;
    end else if (ctrl_wr) begin
      if (write_unlock && prot_change) begin
        write_unlock <= 1'b0;
      end else begin
        write_unlock <= wbyte[BIT_UNLOCK];
      end
    end
  end

  // Protected bits, updated only while unlocked
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      nmi_enable <= RST_NMI_EN;
      count_clock_select <= RST_CLK_SEL;
    end else if (ctrl_wr && write_unlock) begin
      nmi_enable <= wbyte[BIT_NMI_EN];
      count_clock_select <= wbyte[BIT_CLK_SEL];
    end
  end

  // NMI pulse toward the core's level-4 input, vector NMI_VECTOR
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      NMI_REQ <= 1'b0;
    end else begin
      NMI_REQ <= ovf_evt && nmi_enable;
    end
  end

  // Sticky events; a set in the clearing cycle survives
  always_comb begin
    next_status = status;
    if (bus_state == BUS_RD_FETCH && dp_sel == SEL_STAT) begin
      next_status = '0;
    end
    if (ovf_evt) begin
      next_status[STS_OVF] = 1'b1;
    end
    if (ovf_evt && nmi_enable) begin
      next_status[STS_NMI] = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  // Mask register of the same layout
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      mask <= '0;
    end else if (bus_state == BUS_WR && dp_sel == SEL_MASK) begin
      mask <= HWDATA[STS_W-1:0];
    end
  end

  // Level interrupt, high while an unmasked event is pending
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(next_status & mask);
    end
  end

  // Bus slave: writes take no wait, reads one wait so data is fresh
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      bus_state <= BUS_IDLE;
      dp_sel <= SEL_NONE;
      HREADYOUT <= 1'b1;
    end else begin
      case (bus_state)
        BUS_RD_FETCH: begin
          bus_state <= BUS_RD_DONE;
          HREADYOUT <= 1'b1;
        end
        default: begin
          if (addr_ok && HWRITE) begin
            bus_state <= BUS_WR;
            dp_sel <= decode_addr(HADDR);
          end else if (addr_ok) begin
            bus_state <= BUS_RD_FETCH;
            dp_sel <= decode_addr(HADDR);
            HREADYOUT <= 1'b0;
          end else begin
            bus_state <= BUS_IDLE;
            dp_sel <= SEL_NONE;
          end
        end
      endcase
    end
  end

  // Read data; reserved and restart bits read as zero
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      HRDATA <= '0;
    end else if (bus_state == BUS_RD_FETCH) begin
      if (dp_sel == SEL_CTRL) begin
        HRDATA <= {24'h000000, write_unlock, nmi_enable,
                   count_clock_select, 5'h00};
      end else if (dp_sel == SEL_STAT) begin
        HRDATA <= {30'h00000000, status};
      end else if (dp_sel == SEL_MASK) begin
        HRDATA <= {30'h00000000, mask};
      end else begin
        HRDATA <= '0;
      end
    end
  end

  // Every transfer answers OKAY
  always_ff @(posedge CLK) begin
    HRESP <= 1'b0;
  end

  // Checks on the logic above
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  sequence unlocked_write_s;
    ctrl_wr && write_unlock;
  endsequence

  sequence locked_write_s;
    ctrl_wr && !write_unlock;
  endsequence

  sequence ctrl_read_s;
    bus_state == BUS_RD_FETCH && dp_sel == SEL_CTRL;
  endsequence

  // A read holds the bus for exactly one wait cycle
  sequence read_wait_s;
    !HREADYOUT ##1 HREADYOUT;
  endsequence

  reset_values_a: assert property (disable iff (1'b0)
    $past(SYS_RST) |-> (!write_unlock && nmi_enable &&
                        !count_clock_select && count == CNT_RST))
    else $error("control fields wrong after reset");

  restart_clears_a: assert property (
    restart_wr |=> count == CNT_RST)
    else $error("restart did not clear the counter");

  count_advance_a: assert property (
    tick_sel && !restart_wr |=> count == $past(count) + 1'b1)
    else $error("counter did not advance on tick");

  count_frozen_a: assert property (
    !tick_sel && !restart_wr |=> $stable(count))
    else $error("counter moved without a tick");

  overflow_nmi_a: assert property (
    tick_sel && count == CNT_MAX && !restart_wr
    |=> NMI_REQ == $past(nmi_enable) ##1 !NMI_REQ)
    else $error("overflow NMI wrong");

  nmi_cause_a: assert property (
    NMI_REQ |-> $past(ovf_evt) && $past(nmi_enable))
    else $error("NMI without enabled overflow");

  locked_keep_a: assert property (
    locked_write_s |=> $stable(nmi_enable) && $stable(count_clock_select))
    else $error("protected bits changed while locked");

  unlock_once_a: assert property (
    unlocked_write_s ##0 prot_change |=> !write_unlock &&
      nmi_enable == $past(wbyte[BIT_NMI_EN]) &&
      count_clock_select == $past(wbyte[BIT_CLK_SEL]))
    else $error("unlock not consumed by protected write");

  relock_zero_a: assert property (
    unlocked_write_s ##0 (!prot_change && !wbyte[BIT_UNLOCK])
    |=> !write_unlock && $stable(nmi_enable))
    else $error("zero write did not relock");

  ctrl_read_a: assert property (
    ctrl_read_s |=> HREADYOUT && HRDATA[4:0] == 5'h00 &&
                    HRDATA[BIT_UNLOCK] == $past(write_unlock))
    else $error("control byte read wrong");

  fast_tick_a: assert property (
    count_clock_select && osc_tick[1] && !restart_wr |=> count == $past(count) + 1'b1)
    else $error("fast tick did not advance the counter");

  slow_tick_a: assert property (
    !count_clock_select && osc_tick[0] && !restart_wr |=> count == $past(count) + 1'b1)
    else $error("slow tick did not advance the counter");

  nmi_pulse_a: assert property (
    NMI_REQ |=> !NMI_REQ)
    else $error("NMI request longer than one cycle");

  // The level output matches the current status and the mask sampled one edge before it
  irq_level_a: assert property (
    IRQ == |(status & $past(mask)))
    else $error("interrupt level disagrees with status and mask");

  status_clear_a: assert property (
    bus_state == BUS_RD_FETCH && dp_sel == SEL_STAT && !ovf_evt |=> status == '0)
    else $error("status read did not clear");

  status_set_a: assert property (
    ovf_evt |=> status[STS_OVF])
    else $error("overflow event not recorded");

  read_wait_a: assert property (
    addr_ok && !HWRITE |=> read_wait_s)
    else $error("read wait cycle wrong");

  write_nowait_a: assert property (
    addr_ok && HWRITE |=> HREADYOUT)
    else $error("write inserted a wait");
endmodule
`default_nettype wire

// [hw/wdt_pkg.sv]
// Shared constants and types for the watchdog block
package wdt_pkg;
  // Register indices; byte address is four times the index
  localparam logic [31:0] CTRL_IDX = 32'h0000ff53;
  localparam logic [31:0] STAT_IDX = 32'h0000ff54;
  localparam logic [31:0] MASK_IDX = 32'h0000ff55;
  localparam logic [31:0] CTRL_ADDR = {CTRL_IDX[29:0], 2'b00};
  localparam logic [31:0] STAT_ADDR = {STAT_IDX[29:0], 2'b00};
  localparam logic [31:0] MASK_ADDR = {MASK_IDX[29:0], 2'b00};

  // Control byte fields
  localparam int BIT_UNLOCK = 7;
  localparam int BIT_NMI_EN = 6;
  localparam int BIT_CLK_SEL = 5;
  localparam int BIT_RESTART = 0;

  // Reset values of the control fields
  localparam logic RST_UNLOCK = 1'b0;
  localparam logic RST_NMI_EN = 1'b1;
  localparam logic RST_CLK_SEL = 1'b0;

  // Counter and prescaler
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_MAX = 12'hfff;
  localparam logic [CNT_W-1:0] CNT_RST = 12'h000;
  localparam int PRE_W = 4;
  localparam logic [PRE_W-1:0] PRE_MAX = 4'hf;

  // Event status and mask layout
  localparam int STS_W = 2;
  localparam int STS_OVF = 0;
  localparam int STS_NMI = 1;

  // Core-side interrupt identity
  localparam logic [2:0] NMI_LEVEL = 3'h4;
  localparam logic [23:0] NMI_VECTOR = 24'h000004;

  // Register select codes
  typedef enum logic [3:0] {
    SEL_NONE = 4'b0001,
    SEL_CTRL = 4'b0010,
    SEL_STAT = 4'b0100,
    SEL_MASK = 4'b1000
  } wdt_sel_e;

  // Bus slave states
  typedef enum logic [3:0] {
    BUS_IDLE = 4'b0001,
    BUS_WR = 4'b0010,
    BUS_RD_FETCH = 4'b0100,
    BUS_RD_DONE = 4'b1000
  } wdt_bus_e;
endpackage

// [hw/wdt_sync3.sv]
// Three-stage synchroniser with agreement filter for oscillator pins
`timescale 1ns/1ps
`default_nettype none
module wdt_sync3 (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;

  // Only the second stage reads the first
  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Level moves only once two stages agree, filtering a metastable glitch
  always_ff @(posedge clk) begin
    if (rst) begin
      level <= 1'b0;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end
endmodule
`default_nettype wire

// [hw/wdt_tick_div.sv]
// Divide-by-16 prescaler turning oscillator edges into count ticks
`timescale 1ns/1ps
`default_nettype none
module wdt_tick_div
  import wdt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic level,
  output logic tick
);
  logic level_d;
  logic [PRE_W-1:0] pre;
  logic rise;

  assign rise = level & ~level_d;

  // A stopped oscillator gives no edge, so no tick and a frozen count
  always_ff @(posedge clk) begin
    if (rst) begin
      level_d <= 1'b0;
      pre <= '0;
      tick <= 1'b0;
    end else begin
      level_d <= level;
      tick <= rise && (pre == PRE_MAX);
      if (rise) begin
        pre <= pre + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [verif/wdt_core_model.sv]
// Behavioural CPU core that takes the watchdog NMI
`timescale 1ns/1ps
`default_nettype none
module wdt_core_model
  import wdt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic nmi_req,
  input wire logic halt_req,
  output logic halted,
  output logic [7:0] nmi_cnt,
  output logic [23:0] vec
);
  // Halt entered on request; only the NMI pulse leaves it
  always_ff @(posedge clk) begin
    if (rst) begin
      halted <= 1'b0;
    end else if (nmi_req) begin
      halted <= 1'b0;
    end else if (halt_req) begin
      halted <= 1'b1;
    end
  end

  // Count NMIs and fetch the fixed level-4 vector
  always_ff @(posedge clk) begin
    if (rst) begin
      nmi_cnt <= 8'h00;
      vec <= 24'h000000;
    end else if (nmi_req) begin
      nmi_cnt <= nmi_cnt + 8'h01;
      vec <= (NMI_LEVEL == 3'h4) ? NMI_VECTOR : 24'hffffff;
    end
  end
endmodule
`default_nettype wire

// [verif/wdt_top_bench.sv]
// Self-checking bench for the watchdog block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module wdt_top_bench
  import wdt_pkg::*;
;
  logic clk, sys_rst, hsel, hwrite, slow, fast, halt_req;
  logic [31:0] haddr, hwdata, rd;
  logic [2:0] hsize;
  logic [1:0] htrans;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, nmi, irq, halted;
  wire logic [7:0] nmi_cnt;
  wire logic [23:0] vec;
  int error_cnt, n_compared, cyc;
  logic [7:0] wv [8] = '{8'h20, 8'hc0, 8'h40, 8'h60, 8'hc0, 8'he0, 8'h61, 8'h00};
  logic [7:0] ev [8] = '{8'h40, 8'hc0, 8'h40, 8'h40, 8'hc0, 8'h60, 8'h60, 8'h60};

  wdt_top wdt_top_inst (.CLK(clk), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HREADY(hreadyout),
    .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .SLOW_OSC(slow), .FAST_OSC(fast), .NMI_REQ(nmi), .IRQ(irq));
  wdt_core_model wdt_core_model_inst (.clk(clk), .rst(sys_rst), .nmi_req(nmi),
    .halt_req(halt_req), .halted(halted), .nmi_cnt(nmi_cnt), .vec(vec));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic results;
    $display("errors=%0d compared=%0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One overflow needs 65536 pin edges of four cycles; no shorter path exists
  always @(posedge clk) begin
    cyc++;
    if (cyc == 300000) begin
      error_cnt++;
      results();
    end
  end

  // Single AHB transfer; waits on hready in both phases
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    int wt;
    wt = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    // Data phase length: one cycle for writes, two for reads
    do begin
      @(posedge clk);
      wt++;
    end while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK(hresp, 1'b0)
    `CHK(wt, w ? 1 : 2)
  endtask

  // Two cycles high, two low: the shortest pulse the pin filter passes
  task automatic osc(input bit f, input int n);
    for (int i = 0; i < n; i++) begin
      if (f) fast <= 1'b1; else slow <= 1'b1;
      repeat (2) @(posedge clk);
      if (f) fast <= 1'b0; else slow <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  task automatic t_reset;
    bus(1'b0, CTRL_ADDR, 32'h0);
    `CHK(rd, 32'h40)
    bus(1'b0, STAT_ADDR, 32'h0);
    `CHK(rd, 32'h0)
    bus(1'b1, 32'h100, 32'hff);
    bus(1'b0, 32'h100, 32'h0);
    `CHK(rd, 32'h0)
  endtask

  // Unlock, relock, one-shot update and restart read-back
  task automatic t_lock;
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, CTRL_ADDR, {24'h0, wv[i]});
      bus(1'b0, CTRL_ADDR, 32'h0);
      `CHK(rd, {24'h0, ev[i]})
    end
  endtask

  // Restart around a sleep, then a fast tick overflow in HALT with a frozen pause
  task automatic t_overflow;
    halt_req <= 1'b1;
    repeat (2) @(posedge clk);
    halt_req <= 1'b0;
    osc(1'b1, 16);
    bus(1'b1, CTRL_ADDR, 32'h61);
    // Sleep: both pins still
    repeat (64) @(posedge clk);
    bus(1'b1, CTRL_ADDR, 32'h61);
    osc(1'b1, 32768);
    osc(1'b0, 64);
    osc(1'b1, 32752);
    `CHK(nmi_cnt, 8'h00)
    `CHK(halted, 1'b1)
    osc(1'b1, 16);
    repeat (40) @(posedge clk);
    `CHK(nmi_cnt, 8'h01)
    `CHK(vec, NMI_VECTOR)
    `CHK(halted, 1'b0)
    `CHK(irq, 1'b0)
    bus(1'b1, MASK_ADDR, 32'h1);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    bus(1'b0, STAT_ADDR, 32'h0);
    `CHK(rd, 32'h3)
    bus(1'b0, STAT_ADDR, 32'h0);
    `CHK(rd, 32'h0)
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
  endtask

  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    hsize = 3'h2;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    slow = 1'b0;
    fast = 1'b0;
    halt_req = 1'b0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_lock();
    t_overflow();
    results();
  end
endmodule
`default_nettype wire
